/* File: pkg/offset_stage_pkg.sv */
// Constants and carrier types for the antenna-carrier word offset staging logic
package offset_stage_pkg;

	// Channel table geometry
	localparam int CHANNELS     = 32;
	localparam int CH_W         = 5;
	localparam int WORD_W       = 32;
	localparam int SAMPLE_W     = 16;
	localparam int QUAD_WORDS   = 4;
	localparam int QUAD_W       = WORD_W * QUAD_WORDS;
	localparam int LANE_W       = 2;
	localparam int OFFSET_W     = 3;
	localparam int MAX_OFFSET   = 7;
	localparam int COARSE_W     = 8;

	// Offset field layout in aligned uplink mode
	localparam int FINE_LSB     = 0;
	localparam int FINE_MSB     = 1;
	localparam int MATCH_BIT    = 2;
	localparam int COARSE_LSB   = 0;

	// Channel capacity of one eight-times-rate link per sample width
	localparam logic [CH_W:0] CH_LIMIT_15 = 6'h20;
	localparam logic [CH_W:0] CH_LIMIT_16 = 6'h1e;

	// Reset values and the last packer lane
	localparam logic [OFFSET_W-1:0] OFFSET_RST = 3'h0;
	localparam logic [COARSE_W-1:0] COARSE_RST = 8'h00;
	localparam logic [WORD_W-1:0]   WORD_RST   = 32'h0000_0000;
	localparam logic [QUAD_W-1:0]   QUAD_RST   = {QUAD_W{1'b0}};
	localparam logic [LANE_W-1:0]   LANE_LAST  = 2'h3;

	// One chip of word delay, in picoseconds
	localparam int CHIP_PERIOD_PS = 260400;

	typedef struct packed {
		logic              valid;
		logic [CH_W-1:0]   channel;
		logic [WORD_W-1:0] data;
	} word_beat_s;

	typedef struct packed {
		logic                valid;
		logic [CH_W-1:0]     channel;
		logic [QUAD_W-1:0]   data;
	} quad_beat_s;

	typedef struct packed {
		logic                we;
		logic [CH_W-1:0]     channel;
		logic [OFFSET_W-1:0] word_offset;
		logic [COARSE_W-1:0] coarse_offset;
	} table_write_s;

	typedef struct packed {
		logic protocol_cpri;
		logic uplink;
		logic aligned;
		logic sample_16;
	} link_mode_s;

endpackage : offset_stage_pkg

/* File: logic/channel_stager.sv */
// Per-channel word delay line and quad-word packer
`timescale 1ns/1ns
`default_nettype none
module channel_stager
	import offset_stage_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                word_valid,
	input  wire logic [WORD_W-1:0]   word_data,
	input  wire logic [OFFSET_W-1:0] word_offset,
	output logic      [QUAD_W-1:0]   quad_data,
	output logic                     quad_valid
);

	logic [WORD_W-1:0] hist_reg [MAX_OFFSET];
	logic [WORD_W-1:0] acc_reg  [QUAD_WORDS-1];
	logic [LANE_W-1:0] lane_reg;
	logic [WORD_W-1:0] picked;
	logic              lane_full;

	assign picked    = (word_offset == OFFSET_RST) ? word_data : hist_reg[word_offset - 3'h1];
	assign lane_full = (lane_reg == LANE_LAST);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < MAX_OFFSET; i++) begin
				hist_reg[i] <= WORD_RST;
			end
		end else if (word_valid) begin
			hist_reg[0] <= word_data;
			for (int i = 1; i < MAX_OFFSET; i++) begin
				hist_reg[i] <= hist_reg[i-1];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_reg   <= '0;
			quad_data  <= QUAD_RST;
			quad_valid <= 1'b0;
			for (int i = 0; i < QUAD_WORDS-1; i++) begin
				acc_reg[i] <= WORD_RST;
			end
		end else begin
			quad_valid <= word_valid && lane_full;
			if (word_valid) begin
				lane_reg <= lane_reg + 2'h1;
				if (lane_full) begin
					quad_data <= {picked, acc_reg[2], acc_reg[1], acc_reg[0]};
				end else begin
					acc_reg[lane_reg] <= picked;
				end
			end
		end
	end

endmodule // channel_stager
`default_nettype wire

/* File: logic/offset_stage.sv */
// Protocol decoder staging with per antenna-carrier channel word offset
`timescale 1ns/1ns
`default_nettype none
module offset_stage
	import offset_stage_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire link_mode_s   link_mode,
	input  wire table_write_s table_write,
	input  wire word_beat_s   word_in,
	output quad_beat_s        quad_out,
	output logic              word_dropped,
	output logic              offset_mismatch,
	output logic [CH_W:0]     channels_active
);

	// Channel lookup table
	logic [OFFSET_W-1:0] word_offset_reg   [CHANNELS];
	logic [COARSE_W-1:0] coarse_offset_reg [CHANNELS];
	logic [CHANNELS-1:0] seen_reg;

	// Stager wiring
	logic [QUAD_W-1:0]   stg_quad  [CHANNELS];
	logic [CHANNELS-1:0] stg_valid;
	logic [CHANNELS-1:0] stg_write;
	logic [CH_W-1:0]     ch_d1_reg;
	logic                valid_d1_reg;

	// Decode and selection
	wire [CH_W:0]         ch_limit;
	wire                  ch_in_range;
	wire                  accept;
	wire                  offset_enable;
	wire                  sel_valid;
	wire [QUAD_W-1:0]     sel_quad;
	logic [CHANNELS-1:0]  mismatch_vec;
	logic [CH_W:0]        active_next;
	logic                 dropped_next;

	assign ch_limit    = link_mode.sample_16 ? CH_LIMIT_16 : CH_LIMIT_15;
	assign ch_in_range = ({1'b0, word_in.channel} < ch_limit);
	assign accept      = word_in.valid && ch_in_range;

	assign offset_enable = link_mode.protocol_cpri && link_mode.uplink;

	assign sel_valid = stg_valid[ch_d1_reg];
	assign sel_quad  = stg_quad[ch_d1_reg];

	assign dropped_next = word_in.valid && !ch_in_range;

	always_comb begin
		mismatch_vec = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			mismatch_vec[i] = offset_enable && link_mode.aligned &&
				(word_offset_reg[i][MATCH_BIT] != coarse_offset_reg[i][COARSE_LSB]);
		end
	end

	always_comb begin
		active_next = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			active_next = active_next + {{CH_W{1'b0}}, seen_reg[i]};
		end
	end

	// Table writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				word_offset_reg[i]   <= OFFSET_RST;
				coarse_offset_reg[i] <= COARSE_RST;
			end
		end else if (table_write.we) begin
			word_offset_reg[table_write.channel]   <= table_write.word_offset;
			coarse_offset_reg[table_write.channel] <= table_write.coarse_offset;
		end
	end

	// Channels that carried data
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_reg <= '0;
		end else if (accept) begin
			seen_reg[word_in.channel] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch_d1_reg    <= '0;
			valid_d1_reg <= 1'b0;
		end else begin
			ch_d1_reg    <= word_in.channel;
			valid_d1_reg <= accept;
		end
	end

	for (genvar g = 0; g < CHANNELS; g++) begin : g_stage
		wire [OFFSET_W-1:0] eff_offset;

		assign eff_offset   = offset_enable ? word_offset_reg[g] : OFFSET_RST;
		assign stg_write[g] = accept && (word_in.channel == CH_W'(g));

		channel_stager u_stager (
			.ref_clk     (ref_clk),
			.rst_n       (rst_n),
			.word_valid  (stg_write[g]),
			.word_data   (word_in.data),
			.word_offset (eff_offset),
			.quad_data   (stg_quad[g]),
			.quad_valid  (stg_valid[g])
		);
	end

	// Registered outputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			quad_out        <= '0;
			word_dropped    <= 1'b0;
			offset_mismatch <= 1'b0;
			channels_active <= '0;
		end else begin
			quad_out.valid   <= valid_d1_reg && sel_valid;
			quad_out.channel <= ch_d1_reg;
			if (valid_d1_reg && sel_valid) begin
				quad_out.data <= sel_quad;
			end
			word_dropped    <= dropped_next;
			offset_mismatch <= |mismatch_vec;
			channels_active <= active_next;
		end
	end

endmodule // offset_stage
`default_nettype wire

/* File: bench/offset_stage_monitor.sv */
// Assertion checker for the word offset staging ports
`timescale 1ns/1ns
`default_nettype none
module offset_stage_monitor
	import offset_stage_pkg::*;
(
	input wire logic          ref_clk,
	input wire logic          rst_n,
	input wire link_mode_s    link_mode,
	input wire table_write_s  table_write,
	input wire word_beat_s    word_in,
	input wire quad_beat_s    quad_out,
	input wire logic          word_dropped,
	input wire logic          offset_mismatch,
	input wire logic [CH_W:0] channels_active
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_bad_write;
		table_write.we && link_mode.protocol_cpri && link_mode.uplink && link_mode.aligned &&
			table_write.word_offset[MATCH_BIT] != table_write.coarse_offset[COARSE_LSB];
	endsequence
	sequence s_quad;
		quad_out.valid;
	endsequence
	property p_mismatch;
		s_bad_write |-> ##2 offset_mismatch;
	endproperty
	property p_drop;
		word_dropped == $past(word_in.valid && link_mode.sample_16 && word_in.channel >= 5'h1e);
	endproperty
	property p_quad;
		s_quad |-> $past(word_in.valid, 2) && $past(word_in.channel, 2) == quad_out.channel;
	endproperty
	property p_bypass;
		s_quad ##0 !$past(link_mode.protocol_cpri && link_mode.uplink, 2)
			|-> quad_out.data[QUAD_W-1 -: WORD_W] == $past(word_in.data, 2);
	endproperty
	property p_hold;
		!quad_out.valid |-> $stable(quad_out.data);
	endproperty
	property p_active;
		channels_active >= $past(channels_active);
	endproperty
	property p_cap;
		channels_active <= 6'h20;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("offset mismatch not flagged");
	a_drop: assert property (p_drop) else $error("drop pulse wrong");
	a_quad: assert property (p_quad) else $error("quad timing wrong");
	a_bypass: assert property (p_bypass) else $error("offset applied in bypass");
	a_hold: assert property (p_hold) else $error("quad data moved");
	a_active: assert property (p_active) else $error("active count fell");
	a_cap: assert property (p_cap) else $error("active count too big");
endmodule // offset_stage_monitor
bind offset_stage offset_stage_monitor mon (.ref_clk, .rst_n, .link_mode, .table_write, .word_in,
	.quad_out, .word_dropped, .offset_mismatch, .channels_active);
`default_nettype wire

/* File: bench/word_source.sv */
// Far-end radio model feeding antenna-carrier words
`timescale 1ns/1ns
`default_nettype none
module word_source
	import offset_stage_pkg::*;
(
	input  wire logic       ref_clk,
	output var  word_beat_s word_out
);
	initial word_out = '0;
	// Idle beats carry inverted stale data
	task automatic put(input logic v, input logic [CH_W-1:0] ch, input logic [WORD_W-1:0] d);
		@(posedge ref_clk);
		word_out <= v ? {1'b1, ch, d} : {1'b0, word_out.channel, ~word_out.data};
	endtask
endmodule // word_source
`default_nettype wire

/* File: bench/offset_stage_bench.sv */
// Self-checking bench for the word offset staging block
`timescale 1ns/1ns
`default_nettype none
module offset_stage_bench
	import offset_stage_pkg::*;
;
	logic              ref_clk = 0;
	logic              rst_n = 0;
	link_mode_s        link_mode = 4'hc;
	table_write_s      table_write = '0;
	word_beat_s        word_in;
	quad_beat_s        quad_out;
	logic              word_dropped;
	logic              offset_mismatch;
	logic              drop_exp = 1'b0;
	logic [CH_W:0]     channels_active;
	int                co[CHANNELS];
	int                err_count = 0;
	int                total_checks = 0;
	int                seed = 32'h6a63;
	int                off[CHANNELS];
	int                cnt[CHANNELS];
	int                seen[CHANNELS];
	logic [WORD_W-1:0] hist[CHANNELS][$];
	logic [QUAD_W-1:0] pk[CHANNELS];
	logic [CH_W+QUAD_W-1:0] eq[$];
	logic [3:0]        modes[5] = '{4'hc, 4'h4, 4'h8, 4'hd, 4'he};
	always #5 ref_clk = ~ref_clk;
	word_source src (.ref_clk, .word_out(word_in));
	offset_stage dut (.ref_clk, .rst_n, .link_mode, .table_write, .word_in, .quad_out, .word_dropped,
		.offset_mismatch, .channels_active);
	task automatic compare_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic compare_count(input logic [CH_W:0] got, input logic [CH_W:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
		end
	endtask
	// Mismatch flag settles two edges after the last table write
	task automatic check_mismatch;
		logic m;
		m = 1'b0;
		repeat (2) @(negedge ref_clk);
		foreach (off[c]) if (off[c][MATCH_BIT] != co[c][COARSE_LSB]) m = 1'b1;
		compare_flag(offset_mismatch, m && link_mode.protocol_cpri && link_mode.uplink && link_mode.aligned);
	endtask
	task automatic compare(input logic [CH_W+QUAD_W-1:0] got, input logic [CH_W+QUAD_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input int ch, input int o, input int co);
		@(posedge ref_clk);
		table_write <= {1'b1, ch[CH_W-1:0], o[OFFSET_W-1:0], co[COARSE_W-1:0]};
		off[ch] = o;
		co[ch] = co;
	endtask
	task automatic send(input int ch);
		int k;
		logic [WORD_W-1:0] d;
		d = $random(seed);
		src.put(1'b1, ch[CH_W-1:0], d);
		if (link_mode.sample_16 && ch >= 30) return;
		seen[ch] = 1;
		hist[ch].push_back(d);
		k = hist[ch].size() - 1 - ((link_mode.protocol_cpri && link_mode.uplink) ? off[ch] : 0);
		pk[ch][cnt[ch]*WORD_W +: WORD_W] = k < 0 ? '0 : hist[ch][k];
		cnt[ch] = (cnt[ch] + 1) % 4;
		if (cnt[ch] == 0) eq.push_back({ch[CH_W-1:0], pk[ch]});
	endtask
	// Drop pulse follows the taking edge of an out-of-range word
	always @(posedge ref_clk) drop_exp <= word_in.valid && link_mode.sample_16 && ({1'b0, word_in.channel} >= CH_LIMIT_16);
	always @(negedge ref_clk) begin
		if (quad_out.valid === 1'b1) compare({quad_out.channel, quad_out.data}, eq.size() ? eq.pop_front() : 'x);
		if (rst_n) compare_flag(word_dropped, drop_exp);
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 40; i++) send(i % 4);
		src.put(1'b0, 0, 0);
		for (int c = 0; c < CHANNELS; c++) wr(c, c % 8, 0);
		@(posedge ref_clk) table_write.we <= 1'b0;
		check_mismatch();
		foreach (modes[m]) begin
			src.put(1'b0, 0, 0);
			link_mode <= modes[m];
			for (int i = 0; i < 300; i++) send($unsigned($random(seed)) % CHANNELS);
		end
		src.put(1'b0, 0, 0);
		wr(5, 4, 0);
		wr(5, 4, 1);
		@(posedge ref_clk) table_write.we <= 1'b0;
		check_mismatch();
		for (int i = 0; i < 60; i++) send(i % 8);
		src.put(1'b0, 0, 0);
		for (int i = 0; i < 8 && eq.size() > 0; i++) @(posedge ref_clk);
		if (eq.size() > 0) begin
			err_count++;
			$display("MISMATCH %0t quads missing", $time);
		end
		repeat (2) @(negedge ref_clk);
		compare_count(channels_active, (CH_W+1)'(seen.sum()));
		conclude();
	end
endmodule // offset_stage_bench
`default_nettype wire
